// ### pmm_pkg.sv
//==============================================================
// Purpose: shared constants for the paging and linear pointer memory mapper
// Assumes: 8-bit register port, 16-bit cpu space, 17-bit flash space
// Notes:   register offsets sit on the 8-bit register port address
package pmm_pkg;

  // ==========================================================
  // widths
  localparam int CPU_AW = 16;
  localparam int EXT_AW = 17;
  localparam int PAGE_W = 3;
  localparam int DATA_W = 8;
  localparam int REG_AW = 8;

  // ==========================================================
  // paging window: cpu addresses 0x8000-0xBFFF, 16 KB per page
  localparam logic [1:0] WINDOW_TAG = 2'h2; // cpu address bits 15:14
  localparam int WIN_OFS_W = 14;            // cpu address bits 13:0 kept
  localparam logic [PAGE_W-1:0] PAGE_RESET = 3'h2;

  // ==========================================================
  // register offsets on the register port
  localparam logic [REG_AW-1:0] OFS_PAGE_SELECT = 8'h78;
  localparam logic [REG_AW-1:0] OFS_PTR_HIGH = 8'h79;
  localparam logic [REG_AW-1:0] OFS_PTR_MID = 8'h7A;
  localparam logic [REG_AW-1:0] OFS_PTR_LOW = 8'h7B;
  localparam logic [REG_AW-1:0] OFS_BYTE_PORT = 8'h7C;
  localparam logic [REG_AW-1:0] OFS_WORD_INCR = 8'h7D;
  localparam logic [REG_AW-1:0] OFS_BYTE_INCR = 8'h7E; // right after the word port
  localparam logic [REG_AW-1:0] OFS_ADD_BYTE = 8'h7F;

  // ==========================================================
  // reset values and the pointer increment step
  localparam logic [EXT_AW-1:0] PTR_RESET = 17'h00000;
  localparam logic [DATA_W-1:0] ADD_BYTE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RESET = 8'h00;
  localparam logic [EXT_AW-1:0] PTR_STEP = 17'h00001;

endpackage

// ### pmm_xlat_if.sv
//==============================================================
// Purpose: carries the cpu address and page value to the window translator
// Assumes: purely combinational translation
// Notes:   the top owns the page register and registers the results
`timescale 1ns/1ps
interface pmm_xlat_if;
  logic [pmm_pkg::CPU_AW-1:0] cpu_addr;
  logic [pmm_pkg::PAGE_W-1:0] page;
  logic [pmm_pkg::EXT_AW-1:0] ext_addr;
  logic in_window;

  modport owner (output cpu_addr, output page, input ext_addr, input in_window);
  modport xlat (input cpu_addr, input page, output ext_addr, output in_window);
endinterface

// ### pmm_window_xlat.sv
//==============================================================
// Purpose: maps a cpu address to the 17-bit flash address
// Assumes: window is cpu space 0x8000-0xBFFF
// Notes:   outside the window the cpu address passes straight through
`timescale 1ns/1ps
module pmm_window_xlat (
  // translation carrier
  pmm_xlat_if.xlat xif
);

  // ==========================================================
  // window detect and address forming
  wire win_hit;
  wire [pmm_pkg::EXT_AW-1:0] paged_addr;
  wire [pmm_pkg::EXT_AW-1:0] direct_addr;

  // window is the 16 KB block whose top two address bits are 10
  assign win_hit = (xif.cpu_addr[15:14] == pmm_pkg::WINDOW_TAG);
  // page value forms bits 16:14 above cpu bits 13:0
  assign paged_addr = {xif.page, xif.cpu_addr[pmm_pkg::WIN_OFS_W-1:0]};
  // page 1 lands on 0x04000-0x07FFF, the same cells as direct 0x4000-0x7FFF
  assign direct_addr = {1'b0, xif.cpu_addr};
  assign xif.ext_addr = win_hit ? paged_addr : direct_addr;
  assign xif.in_window = win_hit;

endmodule // pmm_window_xlat

// ### pmm_mapper.sv
//==============================================================
// Purpose: program page select, window translation and linear pointer ports
// Assumes: flash side returns lin_rdata combinationally for lin_peek_addr
// Notes:   sequencer page loads win over software writes in the same cycle
//          irq_inhibit is advice to the core, which must honour it
//          page_stack_data and lin_peek_addr mirror the page and pointer registers
`timescale 1ns/1ps
module pmm_mapper (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire logic [pmm_pkg::REG_AW-1:0] reg_addr,
  input wire logic [pmm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pmm_pkg::DATA_W-1:0] reg_rdata,
  // cpu address translation
  input wire logic [pmm_pkg::CPU_AW-1:0] cpu_addr,
  output logic [pmm_pkg::EXT_AW-1:0] ext_addr,
  output logic ext_in_window,
  // linear data path to flash
  output logic [pmm_pkg::EXT_AW-1:0] lin_peek_addr,
  input wire logic [pmm_pkg::DATA_W-1:0] lin_rdata,
  output logic [pmm_pkg::EXT_AW-1:0] lin_addr,
  output logic [pmm_pkg::DATA_W-1:0] lin_wdata,
  output logic lin_wr,
  output logic lin_rd,
  // instruction sequencer
  input wire logic call_begin,
  input wire logic call_page_load,
  input wire logic [pmm_pkg::PAGE_W-1:0] call_page,
  input wire logic rtc_begin,
  input wire logic rtc_page_load,
  input wire logic [pmm_pkg::PAGE_W-1:0] rtc_page,
  input wire logic seq_done,
  output logic [pmm_pkg::PAGE_W-1:0] page_stack_data,
  output logic irq_inhibit
);

  // ==========================================================
  // reset release through two flip-flops
  logic rst_meta;
  logic rst_n;

  // async assert, synchronous release
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================
  // state
  typedef enum logic [1:0] {PMM_IDLE, PMM_CALL, PMM_RTC} pmm_seq_t;

  pmm_seq_t seq_state;
  pmm_seq_t next_seq_state;
  logic [pmm_pkg::PAGE_W-1:0] page_sel;
  logic [pmm_pkg::EXT_AW-1:0] pointer;

  // ==========================================================
  // register decode
  wire hit_page;
  wire hit_ptr_high;
  wire hit_ptr_mid;
  wire hit_ptr_low;
  wire hit_byte;
  wire hit_word_incr;
  wire hit_byte_incr;
  wire hit_add;
  wire hit_data_port;
  wire hit_incr_port;

  assign hit_page = (reg_addr == pmm_pkg::OFS_PAGE_SELECT);
  assign hit_ptr_high = (reg_addr == pmm_pkg::OFS_PTR_HIGH);
  assign hit_ptr_mid = (reg_addr == pmm_pkg::OFS_PTR_MID);
  assign hit_ptr_low = (reg_addr == pmm_pkg::OFS_PTR_LOW);
  assign hit_byte = (reg_addr == pmm_pkg::OFS_BYTE_PORT);
  assign hit_word_incr = (reg_addr == pmm_pkg::OFS_WORD_INCR);
  // byte increment port sits one above the word port so a word access spans both
  assign hit_byte_incr = (reg_addr == pmm_pkg::OFS_BYTE_INCR);
  assign hit_add = (reg_addr == pmm_pkg::OFS_ADD_BYTE);
  assign hit_incr_port = hit_word_incr | hit_byte_incr;
  assign hit_data_port = hit_byte | hit_incr_port;

  // ==========================================================
  // qualified strobes, one per register action
  wire wr_page;
  wire wr_ptr_high;
  wire wr_ptr_mid;
  wire wr_ptr_low;
  wire wr_add;
  wire wr_data_port;
  wire rd_data_port;
  wire any_data_port;

  // a strobe acts only where its address decodes; unmapped accesses fall through
  assign wr_page = reg_wr & hit_page;
  assign wr_ptr_high = reg_wr & hit_ptr_high;
  assign wr_ptr_mid = reg_wr & hit_ptr_mid;
  assign wr_ptr_low = reg_wr & hit_ptr_low;
  assign wr_add = reg_wr & hit_add;
  assign wr_data_port = reg_wr & hit_data_port;
  assign rd_data_port = reg_rd & hit_data_port;
  assign any_data_port = wr_data_port | rd_data_port;

  // ==========================================================
  // pointer next value
  wire [pmm_pkg::EXT_AW-1:0] add_ext;
  wire [pmm_pkg::EXT_AW-1:0] ptr_sum;
  wire [pmm_pkg::EXT_AW-1:0] ptr_inc;
  wire port_access;
  logic [pmm_pkg::EXT_AW-1:0] next_pointer;

  // sign-extend: 0x7F adds 127, 0xFF takes 1, 0x80 takes 128
  assign add_ext = {{(pmm_pkg::EXT_AW-pmm_pkg::DATA_W){reg_wdata[7]}}, reg_wdata};
  // sums are kept to 17 bits, carries out are dropped without notice
  assign ptr_sum = pointer + add_ext;
  assign ptr_inc = pointer + pmm_pkg::PTR_STEP;
  assign port_access = (reg_wr | reg_rd) & hit_incr_port;

  // pointer update: byte writes, add-byte, post-increment
  always_comb begin
    next_pointer = pointer;
    if (wr_ptr_high) begin
      next_pointer = {reg_wdata[0], pointer[15:0]};
    end else if (wr_ptr_mid) begin
      next_pointer = {pointer[16], reg_wdata, pointer[7:0]};
    end else if (wr_ptr_low) begin
      next_pointer = {pointer[16:8], reg_wdata};
    end else if (wr_add) begin
      next_pointer = ptr_sum;
    end else if (port_access) begin
      next_pointer = ptr_inc;
    end
  end

  // ==========================================================
  // call and return sequencing
  wire seq_busy;

  // interrupts are held off from the first step to the resume
  always_comb begin
    next_seq_state = seq_state;
    unique case (seq_state)
      PMM_IDLE: begin
        if (call_begin) begin
          next_seq_state = PMM_CALL;
        end else if (rtc_begin) begin
          next_seq_state = PMM_RTC;
        end
      end
      PMM_CALL: begin
        if (seq_done) begin
          next_seq_state = PMM_IDLE;
        end
      end
      PMM_RTC: begin
        if (seq_done) begin
          next_seq_state = PMM_IDLE;
        end
      end
      default: begin
        next_seq_state = PMM_IDLE;
      end
    endcase
  end

  assign seq_busy = (next_seq_state != PMM_IDLE);

  // ==========================================================
  // page select next value
  logic [pmm_pkg::PAGE_W-1:0] next_page_sel;

  // sequencer loads take priority over a software write
  always_comb begin
    next_page_sel = page_sel;
    if (call_page_load) begin
      next_page_sel = call_page;
    end else if (rtc_page_load) begin
      next_page_sel = rtc_page;
    end else if (wr_page) begin
      next_page_sel = reg_wdata[pmm_pkg::PAGE_W-1:0];
    end
  end

  // ==========================================================
  // read data select
  logic [pmm_pkg::DATA_W-1:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    if (hit_page) begin
      next_rdata = {5'h00, page_sel};
    end else if (hit_ptr_high) begin
      next_rdata = {7'h00, pointer[16]};
    end else if (hit_ptr_mid) begin
      next_rdata = pointer[15:8];
    end else if (hit_ptr_low) begin
      next_rdata = pointer[7:0];
    end else if (hit_data_port) begin
      next_rdata = lin_rdata;
    end else if (hit_add) begin
      next_rdata = 8'h00;
    end
  end

  // ==========================================================
  // window translator
  pmm_xlat_if xif ();

  assign xif.cpu_addr = cpu_addr;
  assign xif.page = page_sel;

  pmm_window_xlat u_xlat (
    .xif(xif.xlat)
  );

  // ==========================================================
  // control registers

  // page select comes out of every reset on page 2
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      page_sel <= pmm_pkg::PAGE_RESET;
    end else begin
      page_sel <= next_page_sel;
    end
  end

  // linear pointer, 17 bits, wraps silently
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pointer <= pmm_pkg::PTR_RESET;
    end else begin
      pointer <= next_pointer;
    end
  end

  // call and return sequence state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      seq_state <= PMM_IDLE;
    end else begin
      seq_state <= next_seq_state;
    end
  end

  // ==========================================================
  // register port read data, valid the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= pmm_pkg::RDATA_RESET;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= pmm_pkg::RDATA_RESET;
    end
  end

  // ==========================================================
  // linear access strobes carry the pointer as it was before the increment
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lin_addr <= pmm_pkg::PTR_RESET;
      lin_wdata <= pmm_pkg::RDATA_RESET;
      lin_wr <= 1'b0;
      lin_rd <= 1'b0;
    end else begin
      lin_wr <= wr_data_port;
      lin_rd <= rd_data_port;
      if (any_data_port) begin
        lin_addr <= pointer;
        lin_wdata <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // translated cpu address, one cycle behind cpu_addr
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_addr <= pmm_pkg::PTR_RESET;
    end else begin
      ext_addr <= xif.ext_addr;
    end
  end

  // window flag, aligned with ext_addr
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_in_window <= 1'b0;
    end else begin
      ext_in_window <= xif.in_window;
    end
  end

  // ==========================================================
  // sequencer outputs: page for stacking and interrupt hold-off
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      page_stack_data <= pmm_pkg::PAGE_RESET;
    end else begin
      page_stack_data <= next_page_sel; // mirrors page_sel
    end
  end

  // hold-off spans the whole call or return sequence
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_inhibit <= 1'b0;
    end else begin
      irq_inhibit <= seq_busy;
    end
  end

  // pointer copy for the flash side's read lookup
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lin_peek_addr <= pmm_pkg::PTR_RESET;
    end else begin
      lin_peek_addr <= next_pointer; // mirrors pointer
    end
  end

endmodule // pmm_mapper

// ### pmm_flash_model.sv
//==============================================================
// Purpose: flash decoder stand-in behind the linear data path
// Assumes: read data follows the peek address with no delay
// Notes:   every byte starts as an address-derived pattern
`timescale 1ns/1ps
module pmm_flash_model (
  // bus side
  input wire logic mclk,
  input wire logic [16:0] peek_addr,
  input wire logic [16:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:131071];
  logic [16:0] i;
  // preload each location with the XOR of its address bytes
  initial begin
    for (int n = 0; n < 131072; n++) begin
      i = 17'(n);
      mem[n] = i[7:0] ^ i[15:8] ^ {7'h00, i[16]};
    end
  end
  // store a byte one cycle after a data-port write
  always @(posedge mclk) begin
    if (wr) mem[addr] <= wdata;
  end
  assign rdata = mem[peek_addr]; // combinational read at the pointer
endmodule // pmm_flash_model

// ### pmm_mapper_assertions.sv
//==============================================================
// Purpose: port-level checks of the page and pointer mapper
// Assumes: internal reset lifts two edges after nrst rises
// Notes:   checks wait three edges after reset release
`timescale 1ns/1ps
module pmm_mapper_assertions (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // translation and linear path
  input wire logic [15:0] cpu_addr,
  input wire logic [16:0] ext_addr,
  input wire logic ext_in_window,
  input wire logic [16:0] lin_peek_addr,
  input wire logic [7:0] lin_rdata,
  input wire logic [16:0] lin_addr,
  input wire logic [7:0] lin_wdata,
  input wire logic lin_wr,
  input wire logic lin_rd,
  // sequencer
  input wire logic call_begin,
  input wire logic call_page_load,
  input wire logic [2:0] call_page,
  input wire logic rtc_begin,
  input wire logic seq_done,
  input wire logic [2:0] page_stack_data,
  input wire logic irq_inhibit
);
  logic [2:0] live;
  // arm the checks once the synchronised reset is gone
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) live <= 3'h0;
    else live <= {live[1:0], 1'b1};
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!live[2]);
  sequence seq_start;
    (call_begin || rtc_begin) && !irq_inhibit && !seq_done;
  endsequence
  sequence seq_end;
    irq_inhibit && seq_done;
  endsequence
  win_map_a: assert property (
    cpu_addr[15:14] == 2'h2 |=> ext_in_window && ext_addr == {$past(page_stack_data), $past(cpu_addr[13:0])})
    else $error("window translation wrong");
  direct_map_a: assert property (
    cpu_addr[15:14] != 2'h2 |=> !ext_in_window && ext_addr == {1'b0, $past(cpu_addr)})
    else $error("direct translation wrong");
  add_read_zero_a: assert property (reg_rd && reg_addr == 8'h7F |=> reg_rdata == 8'h00)
    else $error("add-byte read not zero");
  add_byte_a: assert property (
    reg_wr && reg_addr == 8'h7F |=> lin_peek_addr ==
      $past(lin_peek_addr) + {{9{$past(reg_wdata[7])}}, $past(reg_wdata)})
    else $error("signed add wrong");
  incr_read_a: assert property (
    reg_rd && (reg_addr == 8'h7D || reg_addr == 8'h7E) |=> reg_rdata == $past(lin_rdata)
      && lin_addr == $past(lin_peek_addr) && lin_peek_addr == $past(lin_peek_addr) + 17'h00001)
    else $error("increment port read wrong");
  byte_port_a: assert property ((reg_rd || reg_wr) && reg_addr == 8'h7C |=> $stable(lin_peek_addr))
    else $error("byte port moved the pointer");
  port_write_a: assert property (
    reg_wr && reg_addr == 8'h7D |=> lin_wr && lin_wdata == $past(reg_wdata) && lin_addr == $past(lin_peek_addr))
    else $error("port write wrong");
  port_read_a: assert property (
    reg_rd && reg_addr == 8'h7C |=> lin_rd && !lin_wr && lin_addr == $past(lin_peek_addr))
    else $error("byte port read wrong");
  call_page_a: assert property (call_page_load |=> page_stack_data == $past(call_page))
    else $error("call page not loaded");
  inhibit_set_a: assert property (seq_start |=> irq_inhibit)
    else $error("inhibit not raised");
  inhibit_clear_a: assert property (seq_end |=> !irq_inhibit)
    else $error("inhibit not released");
endmodule // pmm_mapper_assertions
bind pmm_mapper pmm_mapper_assertions chk (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_addr(cpu_addr), .ext_addr(ext_addr),
  .ext_in_window(ext_in_window), .lin_peek_addr(lin_peek_addr), .lin_rdata(lin_rdata), .lin_addr(lin_addr),
  .lin_wdata(lin_wdata), .lin_wr(lin_wr), .lin_rd(lin_rd), .call_begin(call_begin),
  .call_page_load(call_page_load), .call_page(call_page), .rtc_begin(rtc_begin), .seq_done(seq_done),
  .page_stack_data(page_stack_data), .irq_inhibit(irq_inhibit));

// ### pmm_mapper_tb.sv
//==============================================================
// Purpose: self-checking bench for the page and pointer mapper
// Assumes: flash model answers reads at once
// Notes:   each scenario task judges its own results
`timescale 1ns/1ps
module pmm_mapper_tb;
  logic mclk, nrst, reg_wr, reg_rd, ext_in_window, lin_wr, lin_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, lin_rdata, lin_wdata;
  logic [15:0] cpu_addr;
  logic [16:0] ext_addr, lin_peek_addr, lin_addr;
  logic call_begin, call_page_load, rtc_begin, rtc_page_load, seq_done, irq_inhibit;
  logic [2:0] call_page, rtc_page, page_stack_data;
  int miscompares, checked;
  pmm_mapper dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_addr(cpu_addr), .ext_addr(ext_addr),
    .ext_in_window(ext_in_window), .lin_peek_addr(lin_peek_addr), .lin_rdata(lin_rdata), .lin_addr(lin_addr),
    .lin_wdata(lin_wdata), .lin_wr(lin_wr), .lin_rd(lin_rd), .call_begin(call_begin),
    .call_page_load(call_page_load), .call_page(call_page), .rtc_begin(rtc_begin),
    .rtc_page_load(rtc_page_load), .rtc_page(rtc_page), .seq_done(seq_done),
    .page_stack_data(page_stack_data), .irq_inhibit(irq_inhibit));
  pmm_flash_model flash (.mclk(mclk), .peek_addr(lin_peek_addr), .addr(lin_addr),
    .wdata(lin_wdata), .wr(lin_wr), .rdata(lin_rdata));
  // free-running bus clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  function automatic logic [16:0] fpat(input logic [16:0] a);
    return {9'h000, a[7:0] ^ a[15:8] ^ {7'h00, a[16]}};
  endfunction
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [16:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk({9'h000, reg_rdata}, e);
    @(posedge mclk);
  endtask
  task automatic xl(input logic [15:0] a, input logic [16:0] e, input logic w);
    cpu_addr <= a;
    @(posedge mclk);
    #1 chk(ext_addr, e);
    chk(17'(ext_in_window), 17'(w));
    @(posedge mclk);
  endtask
  task automatic t_window();
    for (int p = 0; p < 8; p++) begin
      wr(8'h78, 8'(p));
      rd(8'h78, 17'(p));
      xl(16'h8000, {3'(p), 14'h0000}, 1'b1);
      xl(16'hBFFF, {3'(p), 14'h3FFF}, 1'b1);
    end
    wr(8'h78, 8'h01);
    xl(16'h8123, 17'h04123, 1'b1);
    xl(16'h4123, 17'h04123, 1'b0);
    xl(16'hC000, 17'h0C000, 1'b0);
    xl(16'h7FFF, 17'h07FFF, 1'b0);
  endtask
  task automatic t_linear();
    wr(8'h79, 8'hFF);
    wr(8'h7A, 8'hFF);
    wr(8'h7B, 8'hFE);
    rd(8'h79, 17'h00001);
    rd(8'h7A, 17'h000FF);
    rd(8'h7B, 17'h000FE);
    rd(8'h7C, fpat(17'h1FFFE));
    rd(8'h7D, fpat(17'h1FFFE));
    rd(8'h7E, fpat(17'h1FFFF));
    rd(8'h7E, fpat(17'h00000));
    chk(lin_peek_addr, 17'h00001);
  endtask
  task automatic t_store();
    wr(8'h78, 8'h00);
    wr(8'h79, 8'h00);
    wr(8'h7A, 8'hAB);
    wr(8'h7B, 8'hCD);
    wr(8'h7C, 8'h5A);
    rd(8'h7C, 17'h0005A);
    wr(8'h7D, 8'hA5);
    wr(8'h7E, 8'h3C);
    wr(8'h7F, 8'hFE);
    rd(8'h7E, 17'h000A5);
    rd(8'h7E, 17'h0003C);
  endtask
  task automatic t_add();
    logic [7:0] v [4] = '{8'h7F, 8'hFF, 8'h80, 8'h80};
    logic [16:0] e [4] = '{17'h0008F, 17'h0008E, 17'h0000E, 17'h1FF8E};
    wr(8'h79, 8'h00);
    wr(8'h7A, 8'h00);
    wr(8'h7B, 8'h10);
    for (int k = 0; k < 4; k++) begin
      wr(8'h7F, v[k]);
      chk(lin_peek_addr, e[k]);
    end
    rd(8'h7F, 17'h00000);
    rd(8'h10, 17'h00000);
  endtask
  task automatic seq_run(input logic is_call, input logic [2:0] pg, input logic [2:0] old);
    call_begin <= is_call;
    rtc_begin <= !is_call;
    @(posedge mclk);
    call_begin <= 1'b0;
    rtc_begin <= 1'b0;
    call_page_load <= is_call;
    rtc_page_load <= !is_call;
    call_page <= pg;
    rtc_page <= pg;
    #1 chk(17'(irq_inhibit), 17'h1);
    chk(17'(page_stack_data), 17'(old));
    @(posedge mclk);
    call_page_load <= 1'b0;
    rtc_page_load <= 1'b0;
    seq_done <= 1'b1;
    #1 chk(17'(page_stack_data), 17'(pg));
    @(posedge mclk);
    seq_done <= 1'b0;
    #1 chk(17'(irq_inhibit), 17'h0);
    @(posedge mclk);
  endtask
  task automatic t_seq();
    wr(8'h78, 8'h03);
    seq_run(1'b1, 3'h5, 3'h3);
    xl(16'h8001, 17'h14001, 1'b1);
    seq_run(1'b0, 3'h3, 3'h5);
  endtask
  // reset again mid-run: page back to 2, pointer back to 0
  task automatic t_reset();
    wr(8'h78, 8'h06);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(8'h78, 17'h00002);
    chk(17'(page_stack_data), 17'h2);
    rd(8'h7B, 17'h00000);
    chk(lin_peek_addr, 17'h00000);
  endtask
  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end
  // reset, then the scenarios in turn
  initial begin
    {nrst, reg_wr, reg_rd, call_begin, call_page_load, rtc_begin, rtc_page_load, seq_done} = 8'h00;
    {reg_addr, reg_wdata, cpu_addr, call_page, rtc_page} = 38'h0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(17'(page_stack_data), 17'h2);
    rd(8'h78, 17'h00002);
    t_window();
    t_linear();
    t_store();
    t_add();
    t_seq();
    t_reset();
    tally_and_finish();
  end
endmodule // pmm_mapper_tb
